// ===== wdg_timer.sv
// Watchdog timer with control register and reset-cause flags
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

module wdg_timer #(
   parameter int CNT_W = 20
) (
   // Clock and power-up reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Core and chip signals
   input wire logic osc_128k_i,
   input wire logic restart_i,
   input wire logic irq_ack_i,
   input wire logic global_ie_i,
   input wire logic always_on_fuse_n_i,
   input wire wdg_pkg::wdg_rst_src_t rst_src_i,
   // Outputs
   output logic irq_o,
   output logic wake_o,
   output logic wdog_rst_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [CNT_W-1:0] wdg_last(input logic [3:0] code);
      logic [3:0] c;
      logic [20:0] n;
      c = (code > `WDG_MAX_CODE) ? `WDG_MAX_CODE : code;
      n = (`WDG_BASE_CYCLES << c) - 21'h000001; // RULE23
      return CNT_W'(n);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   wdg_pkg::wdg_ctrl_t ctrl_r;
   logic reset_en_r;
   logic [3:0] prescale_r;
   logic irq_en_r;
   logic irq_flag_r;
   logic [2:0] ce_cnt_r;
   logic [CNT_W-1:0] cnt_r;
   logic [4:0] cause_r;
   logic osc_q_r;
   logic rst_pulse_r;
   logic irq_r;
   logic wake_r;
   logic [7:0] rdata_r;

   logic tick;
   logic wr_ctrl;
   logic wr_cause;
   logic unlock;
   logic ce_open;
   logic timed_wr;
   logic eff_re;
   logic eff_ie;
   logic chip_rst;
   logic timeout;
   logic int_to;
   logic rst_to;
   wdg_pkg::wdg_mode_t mode;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign tick = osc_128k_i & ~osc_q_r; // RULE1
   assign wr_ctrl = wr_i && (addr_i == `WDG_ADDR_CTRL);
   assign wr_cause = wr_i && (addr_i == `WDG_ADDR_CAUSE);
   assign unlock = wr_ctrl && wdata_i[`WDG_CTRL_CE] && wdata_i[`WDG_CTRL_RE]; // RULE8
   assign ce_open = (ce_cnt_r != 3'h0);
   assign timed_wr = wr_ctrl && ce_open && !wdata_i[`WDG_CTRL_CE]; // RULE9
   assign eff_re = ~always_on_fuse_n_i | ctrl_r.reset_en | cause_r[`WDG_CAUSE_WDOG]; // RULE6 RULE21
   assign eff_ie = always_on_fuse_n_i & ctrl_r.irq_en; // RULE6
   assign chip_rst = rst_pulse_r | rst_src_i.scan | rst_src_i.brown | rst_src_i.pin;
   assign ctrl_r = '{irq_flag: irq_flag_r, irq_en: irq_en_r, reset_en: reset_en_r, prescale: prescale_r};

   always_comb begin
      case ({eff_re, eff_ie}) // RULE7
         2'b01: mode = wdg_pkg::WDG_IRQ;
         2'b10: mode = wdg_pkg::WDG_RESET;
         2'b11: mode = wdg_pkg::WDG_IRQ_RESET;
         default: mode = wdg_pkg::WDG_STOPPED;
      endcase
   end

   assign timeout = tick && !restart_i && (mode != wdg_pkg::WDG_STOPPED) && (cnt_r == wdg_last(ctrl_r.prescale));

   always_comb begin
      int_to = 1'b0;
      rst_to = 1'b0;
      case (mode)
         wdg_pkg::WDG_IRQ: int_to = timeout; // RULE3
         wdg_pkg::WDG_RESET: rst_to = timeout; // RULE4
         wdg_pkg::WDG_IRQ_RESET: begin
            int_to = timeout && !ctrl_r.irq_flag; // RULE5
            rst_to = timeout && ctrl_r.irq_flag; // RULE20
         end
         default: begin
            int_to = 1'b0;
            rst_to = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Oscillator edge
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         osc_q_r <= 1'b0;
      end else begin
         osc_q_r <= osc_128k_i;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
      end else if (chip_rst || restart_i || mode == wdg_pkg::WDG_STOPPED) begin
         cnt_r <= '0; // RULE2
      end else if (timeout) begin
         cnt_r <= '0; // RULE24
      end else if (tick) begin
         cnt_r <= cnt_r + CNT_W'(1); // RULE1
      end
   end

   // ----------------------------------------
   // Change window
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ce_cnt_r <= 3'h0;
      end else if (chip_rst) begin
         ce_cnt_r <= 3'h0;
      end else if (unlock && !ce_open) begin
         ce_cnt_r <= `WDG_CE_CYCLES; // RULE22
      end else if (timed_wr) begin
         ce_cnt_r <= 3'h0; // RULE9
      end else if (ce_open) begin
         ce_cnt_r <= ce_cnt_r - 3'h1; // RULE22
      end
   end

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reset_en_r <= 1'b0;
         prescale_r <= 4'h0;
      end else if (chip_rst) begin
         reset_en_r <= 1'b0;
         prescale_r <= 4'h0;
      end else if (timed_wr) begin
         // Pending watchdog reset flag or fuse keeps the stored enable set
         reset_en_r <= wdata_i[`WDG_CTRL_RE] | cause_r[`WDG_CAUSE_WDOG] | ~always_on_fuse_n_i; // RULE9 RULE21
         prescale_r <= {wdata_i[`WDG_CTRL_P3], wdata_i[2:0]}; // RULE9
      end else if (wr_ctrl && wdata_i[`WDG_CTRL_RE]) begin
         reset_en_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_en_r <= 1'b0;
      end else if (chip_rst) begin
         irq_en_r <= 1'b0;
      end else if (wr_ctrl) begin
         irq_en_r <= wdata_i[`WDG_CTRL_IE];
      end else if (irq_ack_i && mode == wdg_pkg::WDG_IRQ_RESET) begin
         irq_en_r <= 1'b0; // RULE19
      end
   end

   // Set beats a clear in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_flag_r <= 1'b0;
      end else if (chip_rst) begin
         irq_flag_r <= 1'b0;
      end else if (int_to) begin
         irq_flag_r <= 1'b1; // RULE17
      end else if (irq_ack_i || (wr_ctrl && wdata_i[`WDG_CTRL_IF])) begin
         irq_flag_r <= 1'b0; // RULE17 RULE19
      end
   end

   // ----------------------------------------
   // Reset-cause flags
   // ----------------------------------------
   // Power-up reset is sys_rst_i: it clears all but the power flag
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cause_r <= `WDG_CAUSE_RST; // RULE16
      end else begin
         cause_r <= (wr_cause ? wdata_i[4:0] : cause_r)
                    | {rst_src_i.scan, rst_to, rst_src_i.brown, rst_src_i.pin, 1'b0}; // RULE12 RULE13 RULE14 RULE15
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_pulse_r <= 1'b0;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         rst_pulse_r <= rst_to; // RULE4 RULE20
         irq_r <= ctrl_r.irq_flag && eff_ie && global_ie_i; // RULE18
         wake_r <= ctrl_r.irq_flag && eff_ie; // RULE3
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_r <= 8'h00;
      end else if (rd_i && addr_i == `WDG_ADDR_CTRL) begin
         rdata_r <= {ctrl_r.irq_flag, eff_ie, ctrl_r.prescale[3], ce_open, eff_re,
                     ctrl_r.prescale[2:0]}; // RULE21
      end else if (rd_i && addr_i == `WDG_ADDR_CAUSE) begin
         rdata_r <= {3'h0, cause_r};
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata_o = rdata_r;
   assign irq_o = irq_r;
   assign wake_o = wake_r;
   assign wdog_rst_o = rst_pulse_r;

endmodule
`default_nettype wire

// ===== wdg_consts.svh
// Constants for the watchdog timer and reset-cause block
//
// Operation
// [RULE1] Counter advances only on ticks of the separate 128kHz oscillator.
// [RULE2] Restart instruction clears the counter; software must restart before time-out.
// [RULE3] Interrupt mode time-out raises the interrupt request, which also wakes from sleep.
// [RULE4] Reset mode time-out generates a system reset.
// [RULE5] Combined mode: first time-out interrupts, later time-out resets.
// [RULE6] Programmed always-on fuse forces reset enable 1, interrupt enable 0.
// [RULE7] Unfused mode from reset/irq enables: 00 stop, 01 irq, 10 reset, 11 both.
// [RULE8] Unlock by writing change enable and reset enable both one together.
// [RULE9] New reset enable and prescale accepted only within four cycles, change enable zero; here any control write with bit 3 one sets reset enable.
// [RULE10] Software should restart the counter before changing the prescaler.
// [RULE11] Software should clear reset flag and reset enable during initialisation.
// [RULE12] Bit 4 sets on scan-chain reset; cleared by power-up or written zero.
// [RULE13] Bit 3 sets on watchdog reset; cleared by power-up or written zero.
// [RULE14] Bit 2 sets on brown-out reset; cleared by power-up or written zero.
// [RULE15] Bit 1 sets on pin reset; cleared by power-up or written zero.
// [RULE16] Bit 0 sets on power-up; cleared only by a written zero.
// [RULE17] Interrupt flag bit 7 sets on interrupt time-out; vector or written one clears.
// [RULE18] Interrupt taken only with global enable, irq enable and pending flag.
// [RULE19] Combined mode vector clears irq enable and flag, leaving reset mode.
// [RULE20] Combined mode time-out with interrupt still pending applies system reset.
// [RULE21] Reset enable reads and acts as set while the watchdog reset flag is set.
// [RULE22] Change enable clears itself four clock cycles after being written.
// [RULE23] Prescale code n 0..9 gives 2048 shl n cycles; codes 10..15 reserved; here codes 10..15 act as code 9.
// [RULE24] Interrupt-mode time-out restarts counter so interrupts recur each period.
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

`define WDG_ADDR_CTRL 8'h60
`define WDG_ADDR_CAUSE 8'h54

`define WDG_CTRL_IF 7
`define WDG_CTRL_IE 6
`define WDG_CTRL_P3 5
`define WDG_CTRL_CE 4
`define WDG_CTRL_RE 3

`define WDG_CAUSE_SCAN 4
`define WDG_CAUSE_WDOG 3
`define WDG_CAUSE_BROWN 2
`define WDG_CAUSE_PIN 1
`define WDG_CAUSE_PWR 0
`define WDG_CAUSE_RST 5'h01
`define WDG_CAUSE_MASK 8'h1F

`define WDG_CE_CYCLES 3'h4
`define WDG_BASE_CYCLES 21'h000800
`define WDG_MAX_CODE 4'h9

`endif

// ===== wdg_pkg.sv
// Types shared by the watchdog timer block
package wdg_pkg;

   typedef enum logic [1:0] {
      WDG_STOPPED,
      WDG_IRQ,
      WDG_RESET,
      WDG_IRQ_RESET
   } wdg_mode_t;

   typedef struct packed {
      logic irq_flag;
      logic irq_en;
      logic reset_en;
      logic [3:0] prescale;
   } wdg_ctrl_t;

   typedef struct packed {
      logic scan;
      logic brown;
      logic pin;
   } wdg_rst_src_t;

endpackage

// ===== wdg_timer_monitor.sv
// Port checker for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module wdg_timer_monitor #(
   parameter int CNT_W = 20
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Core signals
   input wire logic restart_i,
   input wire logic global_ie_i,
   input wire logic always_on_fuse_n_i,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire logic wdog_rst_o
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_unmapped; $past(rd_i) && $past(addr_i) != 8'h60 && $past(addr_i) != 8'h54 |-> rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst_pulse; wdog_rst_o |=> !wdog_rst_o; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   property p_rst_clear; wdog_rst_o |-> ##2 !wake_o; endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("wake after watchdog reset");
   property p_restart; restart_i |=> !wdog_rst_o [*2]; endproperty
   a_restart: assert property (p_restart) else $error("time-out right after restart");
   property p_irq_wake; irq_o |-> wake_o; endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
   property p_irq_gie; irq_o |-> $past(global_ie_i); endproperty
   a_irq_gie: assert property (p_irq_gie) else $error("irq with global enable low");
   property p_fuse_rd; $past(rd_i) && $past(addr_i) == 8'h60 && !always_on_fuse_n_i |-> rdata_o[3] && !rdata_o[6]; endproperty
   a_fuse_rd: assert property (p_fuse_rd) else $error("fuse mode bits wrong");
   property p_fuse_wake; !always_on_fuse_n_i |-> !wake_o; endproperty
   a_fuse_wake: assert property (p_fuse_wake) else $error("wake while fuse forces reset");
endmodule
bind wdg_timer wdg_timer_monitor #(.CNT_W(CNT_W)) u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .restart_i(restart_i), .global_ie_i(global_ie_i),
   .always_on_fuse_n_i(always_on_fuse_n_i), .irq_o(irq_o), .wake_o(wake_o), .wdog_rst_o(wdog_rst_o));
`default_nettype wire

// ===== watchdog_timer_with_reset_flags_test.sv
// Self-checking bench for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_with_reset_flags_test;
   logic clk_i, sys_rst_i, wr_i, rd_i, osc_128k_i, restart_i, irq_ack_i, global_ie_i, always_on_fuse_n_i;
   logic [7:0] addr_i, wdata_i, rdata_o;
   logic irq_o, wake_o, wdog_rst_o;
   wdg_pkg::wdg_rst_src_t rst_src_i;
   int err_total = 0;
   int n_tests = 0;
   int rst_cnt = 0;
   wdg_timer #(.CNT_W(20)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_128k_i(osc_128k_i), .restart_i(restart_i),
      .irq_ack_i(irq_ack_i), .global_ie_i(global_ie_i), .always_on_fuse_n_i(always_on_fuse_n_i),
      .rst_src_i(rst_src_i), .irq_o(irq_o), .wake_o(wake_o), .wdog_rst_o(wdog_rst_o));
   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   always @(posedge clk_i) if (wdog_rst_o === 1'b1) rst_cnt++;
   task automatic summarize();
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(nm, rdata_o, exp);
   endtask
   task automatic strobe(input bit ack);
      @(posedge clk_i);
      if (ack) irq_ack_i <= 1'b1; else restart_i <= 1'b1;
      @(posedge clk_i);
      irq_ack_i <= 1'b0;
      restart_i <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         osc_128k_i <= 1'b0;
         @(posedge clk_i);
         osc_128k_i <= 1'b1;
      end
      repeat (6) @(posedge clk_i);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_irq();
      wr(8'h60, 8'h40);
      strobe(0);
      tick(2047);
      rd_chk("flag early", 8'h60, 8'h40);
      tick(1);
      rd_chk("flag set", 8'h60, 8'hC0);
      chk("irq", 8'(irq_o), 8'h01);
      @(posedge clk_i);
      global_ie_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("irq masked", 8'(irq_o), 8'h00);
      chk("wake", 8'(wake_o), 8'h01);
      strobe(1);
      rd_chk("flag acked", 8'h60, 8'h40);
      tick(2048);
      rd_chk("flag again", 8'h60, 8'hC0);
      wr(8'h60, 8'hC0);
      rd_chk("flag w1c", 8'h60, 8'h40);
      chk("no reset", 8'(rst_cnt), 8'h00);
      wr(8'h60, 8'h00);
   endtask
   task automatic t_comb();
      wr(8'h60, 8'h48);
      strobe(0);
      tick(2048);
      rd_chk("comb flag", 8'h60, 8'hC8);
      chk("comb no reset", 8'(rst_cnt), 8'h00);
      strobe(1);
      rd_chk("comb vector", 8'h60, 8'h08);
      strobe(0);
      tick(2048);
      chk("reset pulse", 8'(rst_cnt), 8'h01);
      rd_chk("cause wdog", 8'h54, 8'h09);
      rd_chk("re forced", 8'h60, 8'h08);
   endtask
   task automatic t_lock();
      wr(8'h60, 8'h18);
      wr(8'h60, 8'h00);
      rd_chk("re held", 8'h60, 8'h08);
      wr(8'h54, 8'h00);
      rd_chk("cause clr", 8'h54, 8'h00);
      wr(8'h60, 8'h00);
      rd_chk("locked", 8'h60, 8'h08);
      wr(8'h60, 8'h18);
      rd_chk("ce open", 8'h60, 8'h18);
      repeat (6) @(posedge clk_i);
      rd_chk("ce closed", 8'h60, 8'h08);
      strobe(0);
      wr(8'h60, 8'h18);
      wr(8'h60, 8'h01);
      rd_chk("unlocked", 8'h60, 8'h01);
      wr(8'h60, 8'h0F);
      rd_chk("ps locked", 8'h60, 8'h09);
   endtask
   task automatic t_src();
      logic [7:0] exp [3] = '{8'h02, 8'h04, 8'h10};
      for (int i = 0; i < 3; i++) begin
         wr(8'h54, 8'h00);
         @(posedge clk_i);
         rst_src_i <= wdg_pkg::wdg_rst_src_t'(3'h1 << i);
         @(posedge clk_i);
         rst_src_i <= '0;
         rd_chk("cause src", 8'h54, exp[i]);
      end
      rd_chk("ctrl src", 8'h60, 8'h00);
   endtask
   task automatic t_pend();
      wr(8'h60, 8'h48);
      strobe(0);
      tick(2048);
      chk("pend no reset", 8'(rst_cnt), 8'h01);
      tick(2048);
      chk("pend reset", 8'(rst_cnt), 8'h02);
      rd_chk("pend cause", 8'h54, 8'h18);
   endtask
   task automatic t_fuse();
      @(posedge clk_i);
      always_on_fuse_n_i <= 1'b0;
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_chk("cause por", 8'h54, 8'h01);
      rd_chk("fuse", 8'h60, 8'h08);
      wr(8'h60, 8'h40);
      rd_chk("fuse ie", 8'h60, 8'h08);
      wr(8'h60, 8'h18);
      wr(8'h60, 8'h00);
      rd_chk("fuse re", 8'h60, 8'h08);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      {sys_rst_i, always_on_fuse_n_i, global_ie_i} = 3'h7;
      {wr_i, rd_i, osc_128k_i, restart_i, irq_ack_i} = 5'h00;
      {addr_i, wdata_i} = 16'h0000;
      rst_src_i = '0;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_chk("ctrl rst", 8'h60, 8'h00);
      rd_chk("cause rst", 8'h54, 8'h01);
      rd_chk("unmapped", 8'h33, 8'h00);
      t_irq();
      t_comb();
      t_lock();
      t_src();
      t_pend();
      t_fuse();
      summarize();
   end
endmodule
`default_nettype wire
